// ---- design/tmw_map.vh ----
`ifndef TMW_MAP_VH
`define TMW_MAP_VH
// register indices on the plain register port
`define TMW_ADDR_W 3
`define TMW_REG_CTRL 3'h0
`define TMW_REG_CNT 3'h1
`define TMW_REG_CMP 3'h2
`define TMW_REG_MASK 3'h3
`define TMW_REG_FLAGS 3'h4
// control field positions
`define TMW_CTRL_FORCE 7
`define TMW_CTRL_WGM_HI 6
`define TMW_CTRL_WGM_LO 3
`define TMW_CTRL_COM_HI 5
`define TMW_CTRL_COM_LO 4
`define TMW_CTRL_CS_HI 2
`define TMW_CTRL_CS_LO 0
// flag and mask bit positions
`define TMW_BIT_CMP 1
`define TMW_BIT_OVF 0
// waveform modes
`define TMW_MODE_NORMAL 2'h0
`define TMW_MODE_PCPWM 2'h1
`define TMW_MODE_CTC 2'h2
`define TMW_MODE_FPWM 2'h3
// compare output modes
`define TMW_COM_OFF 2'h0
`define TMW_COM_TOGGLE 2'h1
`define TMW_COM_CLEAR 2'h2
`define TMW_COM_SET 2'h3
// clock select codes
`define TMW_CS_STOP 3'h0
`define TMW_CS_DIV1 3'h1
`define TMW_CS_DIV8 3'h2
`define TMW_CS_DIV64 3'h3
`define TMW_CS_DIV256 3'h4
`define TMW_CS_DIV1024 3'h5
`define TMW_CS_EXT_FALL 3'h6
`define TMW_CS_EXT_RISE 3'h7
// prescaler tap bit positions (divide by 2^(n+1))
`define TMW_TAP_DIV8 2
`define TMW_TAP_DIV64 5
`define TMW_TAP_DIV256 7
`define TMW_TAP_DIV1024 9
`define TMW_PRE_W 10
// counter landmarks
`define TMW_MAX 8'hff
`define TMW_BOTTOM 8'h00
`define TMW_ZERO8 8'h00
`endif

// ---- design/tmw_tick_gen.v ----
`include "tmw_map.vh"
`default_nettype none
// builds the single-cycle timer tick enable from the selected source
module tmw_tick_gen
(
    input wire i_clk,
    input wire i_sys_rst,
    input wire [2:0] i_clk_sel,
    input wire i_ext_pin,
    output reg o_tick
);
    reg [`TMW_PRE_W-1:0] pre_r; // free-running prescaler
    reg [`TMW_PRE_W-1:0] pre_d_r; // previous prescaler value
    reg ext_s1_r; // synchroniser first stage, read only by stage two
    reg ext_s2_r; // synchronised pin level
    reg ext_s3_r; // delayed level for edge detection
    wire [`TMW_PRE_W-1:0] pre_fall;
    reg tick_nxt;

    // a tap completing its period shows as its bit falling
    assign pre_fall = pre_d_r & ~pre_r;

    // prescaler and pin synchroniser
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            pre_r <= {`TMW_PRE_W{1'b0}};
            pre_d_r <= {`TMW_PRE_W{1'b0}};
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end
        else
        begin
            pre_r <= pre_r + {{(`TMW_PRE_W-1){1'b0}}, 1'b1};
            pre_d_r <= pre_r;
            ext_s1_r <= i_ext_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // source selection; the pin is sampled whatever its direction
    always @*
    begin
        case (i_clk_sel)
            `TMW_CS_STOP: tick_nxt = 1'b0;
            `TMW_CS_DIV1: tick_nxt = 1'b1;
            `TMW_CS_DIV8: tick_nxt = pre_fall[`TMW_TAP_DIV8];
            `TMW_CS_DIV64: tick_nxt = pre_fall[`TMW_TAP_DIV64];
            `TMW_CS_DIV256: tick_nxt = pre_fall[`TMW_TAP_DIV256];
            `TMW_CS_DIV1024: tick_nxt = pre_fall[`TMW_TAP_DIV1024];
            `TMW_CS_EXT_FALL: tick_nxt = ext_s3_r & ~ext_s2_r;
            `TMW_CS_EXT_RISE: tick_nxt = ~ext_s3_r & ext_s2_r;
            default: tick_nxt = 1'b0;
        endcase
    end

    // tick is a one-cycle enable on the single clock
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_tick <= 1'b0;
        else
            o_tick <= tick_nxt;
    end
endmodule
`default_nettype wire

// ---- design/tmw_timer8.v ----
// Functional notes
// - force strobe applies compare action to output
// - force only acts in non-PWM modes
// - force sets no flag, no CTC clear
// - force bit always reads zero
// - mode field bits 6,3 pick mode
// - TOP and compare buffering per mode
// - overflow at MAX, or at bottom turnaround
// - nonzero output mode overrides port pin
// - non-PWM: toggle, clear or set on match
// - fast PWM: match and TOP actions
// - phase PWM: up and down match actions
// - fast PWM: compare at TOP ignored, TOP action kept
// - clock select: stop, prescaled, external edges
// - external pin counts even as output
// - counter writable; write blocks next match
// - continuous compare sets flag, drives output
// - compare flag cleared by vector or one
// - overflow flag cleared by vector or one
// - request needs flag, enable, global bit
// - mask upper bits read zero, reset zero
// - tick is an enable, single clock
// - fast PWM wraps MAX to zero
// - phase PWM holds MAX one tick
//
// Design decisions made here: the strobed register port and the register offsets.
`include "tmw_map.vh"
`default_nettype none
module tmw_timer8
(
    input wire i_clk,
    input wire i_sys_rst,
    input wire [`TMW_ADDR_W-1:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire i_ext_pin,
    input wire i_global_irq_en,
    input wire i_cmp_vector_ack,
    input wire i_ovf_vector_ack,
    output reg o_cmp_irq,
    output reg o_ovf_irq,
    output reg o_wave,
    output reg o_wave_override
);
    reg [7:0] ctrl_r; // control, force bit never stored
    reg [7:0] cnt_r; // counter value
    reg [7:0] cmp_r; // compare value as written
    reg [7:0] cmp_act_r; // compare value in use
    reg [1:0] mask_r; // enable bits
    reg cmp_flag_r;
    reg ovf_flag_r;
    reg down_r; // phase pwm direction
    reg wave_r; // waveform output register
    reg block_r; // match blocked after counter write
    wire tick; // one-cycle timer tick enable
    wire [1:0] mode; // decoded waveform mode
    wire [1:0] com; // compare output mode
    wire is_pwm; // either pwm mode selected
    wire [7:0] top; // highest value of the count sequence
    wire match; // counter equals compare value in use
    wire match_ok; // match that counts on this tick
    wire wr_ctrl; // control register write
    wire wr_cnt; // counter write
    wire wr_cmp; // compare register write
    wire wr_mask; // mask register write
    wire wr_flags; // flag register write
    wire cmp_clr; // compare flag clear request
    wire ovf_clr; // overflow flag clear request
    wire wave_on; // output connected to the pin
    wire pc_down; // phase pwm direction as a match sees it
    wire force_cmp; // forced compare strobe accepted
    reg [7:0] cnt_nxt;
    reg down_nxt;
    reg ovf_set;
    reg at_top;
    reg wave_nxt;
    reg [7:0] rdata_nxt;

    tmw_tick_gen tmw_tick_gen_inst
    (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_sel(ctrl_r[`TMW_CTRL_CS_HI:`TMW_CTRL_CS_LO]),
        .i_ext_pin(i_ext_pin),
        .o_tick(tick)
    );

    // mode field bits are split across the register
    assign mode = {ctrl_r[`TMW_CTRL_WGM_HI], ctrl_r[`TMW_CTRL_WGM_LO]};
    assign com = ctrl_r[`TMW_CTRL_COM_HI:`TMW_CTRL_COM_LO];
    assign is_pwm = (mode == `TMW_MODE_PCPWM) | (mode == `TMW_MODE_FPWM);
    assign top = (mode == `TMW_MODE_CTC) ? cmp_act_r : `TMW_MAX;
    assign wr_ctrl = i_wr & (i_addr == `TMW_REG_CTRL);
    assign wr_cnt = i_wr & (i_addr == `TMW_REG_CNT);
    assign wr_cmp = i_wr & (i_addr == `TMW_REG_CMP);
    assign wr_mask = i_wr & (i_addr == `TMW_REG_MASK);
    assign wr_flags = i_wr & (i_addr == `TMW_REG_FLAGS);
    // flags clear by vector or by a written one, never by a zero
    assign cmp_clr = i_cmp_vector_ack | (wr_flags & i_wdata[`TMW_BIT_CMP]);
    assign ovf_clr = i_ovf_vector_ack | (wr_flags & i_wdata[`TMW_BIT_OVF]);
    assign wave_on = (com != `TMW_COM_OFF);
    // bottom counts as up-counting, so a compare at zero keeps it low
    assign pc_down = down_r & (cnt_r != `TMW_BOTTOM);
    // both pwm modes have the low mode bit set; the strobe is judged
    // by the mode written beside it, not by the one being replaced
    assign force_cmp = wr_ctrl & i_wdata[`TMW_CTRL_FORCE] &
                       ~i_wdata[`TMW_CTRL_WGM_LO];
    assign match = (cnt_r == cmp_act_r);
    // match counts on a tick unless a counter write blocked it
    assign match_ok = tick & match & ~block_r;

    // next count, direction and overflow
    always @*
    begin
        cnt_nxt = cnt_r;
        down_nxt = down_r;
        ovf_set = 1'b0;
        at_top = 1'b0;
        case (mode)
            `TMW_MODE_PCPWM:
            begin
                if (!down_r)
                begin
                    if (cnt_r == `TMW_MAX)
                    begin
                        // hold MAX one tick then turn
                        down_nxt = 1'b1;
                        cnt_nxt = cnt_r - 8'h01;
                    end
                    else
                        cnt_nxt = cnt_r + 8'h01;
                end
                else if (cnt_r == `TMW_BOTTOM)
                begin
                    down_nxt = 1'b0;
                    cnt_nxt = cnt_r + 8'h01;
                    ovf_set = 1'b1;
                end
                else
                    cnt_nxt = cnt_r - 8'h01;
            end
            `TMW_MODE_CTC:
            begin
                down_nxt = 1'b0;
                cnt_nxt = (match & ~block_r) ? `TMW_ZERO8 : cnt_r + 8'h01;
                ovf_set = (cnt_r == `TMW_MAX);
            end
            default:
            begin
                // normal and fast pwm wrap MAX to zero
                down_nxt = 1'b0;
                cnt_nxt = cnt_r + 8'h01;
                ovf_set = (cnt_r == `TMW_MAX);
                at_top = (mode == `TMW_MODE_FPWM) & (cnt_r == `TMW_MAX);
            end
        endcase
    end

    // waveform output decisions
    always @*
    begin
        wave_nxt = wave_r;
        if (force_cmp)
        begin
            // forced match uses new output mode bits
            case (i_wdata[`TMW_CTRL_COM_HI:`TMW_CTRL_COM_LO])
                `TMW_COM_TOGGLE: wave_nxt = ~wave_r;
                `TMW_COM_CLEAR: wave_nxt = 1'b0;
                `TMW_COM_SET: wave_nxt = 1'b1;
                default: wave_nxt = wave_r;
            endcase
        end
        else if (tick)
        begin
            case (mode)
                `TMW_MODE_FPWM:
                begin
                    // compare at TOP yields to the TOP action
                    if (at_top & com[1])
                        wave_nxt = ~com[0];
                    else if (match_ok & com[1] & (cmp_act_r != `TMW_MAX))
                        wave_nxt = com[0];
                end
                `TMW_MODE_PCPWM:
                begin
                    if (match_ok & com[1] & (cmp_act_r == `TMW_MAX))
                        wave_nxt = ~com[0];
                    else if (match_ok & com[1])
                        wave_nxt = pc_down ? ~com[0] : com[0];
                end
                default:
                begin
                    if (match_ok)
                    begin
                        case (com)
                            `TMW_COM_TOGGLE: wave_nxt = ~wave_r;
                            `TMW_COM_CLEAR: wave_nxt = 1'b0;
                            `TMW_COM_SET: wave_nxt = 1'b1;
                            default: wave_nxt = wave_r;
                        endcase
                    end
                end
            endcase
        end
    end

    // register read mux
    always @*
    begin
        case (i_addr)
            `TMW_REG_CTRL:
            begin
                rdata_nxt = ctrl_r;
                rdata_nxt[`TMW_CTRL_FORCE] = 1'b0;
            end
            `TMW_REG_CNT: rdata_nxt = cnt_r;
            `TMW_REG_CMP: rdata_nxt = cmp_r;
            `TMW_REG_MASK: rdata_nxt = {6'h00, mask_r};
            `TMW_REG_FLAGS: rdata_nxt = {6'h00, cmp_flag_r, ovf_flag_r};
            default: rdata_nxt = `TMW_ZERO8;
        endcase
    end

    // register file: control, compare and mask
    // the force bit is a strobe, so the control copy never keeps it
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ctrl_r <= `TMW_ZERO8;
            cmp_r <= `TMW_ZERO8;
            mask_r <= 2'h0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_r <= i_wdata;
                ctrl_r[`TMW_CTRL_FORCE] <= 1'b0;
            end
            if (wr_cmp)
                cmp_r <= i_wdata;
            if (wr_mask)
                mask_r <= i_wdata[`TMW_BIT_CMP:`TMW_BIT_OVF];
        end
    end

    // compare value in use; in pwm it moves only at TOP, so one
    // period never sees two thresholds and cannot glitch
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
            cmp_act_r <= `TMW_ZERO8;
        else if (!is_pwm)
            cmp_act_r <= cmp_r;
        else if (tick & (cnt_r == top))
            cmp_act_r <= cmp_r;
    end

    // counter, direction and match blocking
    // a software write wins over a tick in the same cycle
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            cnt_r <= `TMW_ZERO8;
            down_r <= 1'b0;
            block_r <= 1'b0;
        end
        else if (wr_cnt)
        begin
            cnt_r <= i_wdata;
            block_r <= 1'b1;
        end
        else if (tick)
        begin
            cnt_r <= cnt_nxt;
            down_r <= down_nxt;
            block_r <= 1'b0;
        end
    end

    // status flags; a hardware set wins over a clear in the same
    // cycle, so an event is never lost to a late acknowledge
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            cmp_flag_r <= 1'b0;
            ovf_flag_r <= 1'b0;
        end
        else
        begin
            // a forced compare never reaches match_ok
            if (match_ok)
                cmp_flag_r <= 1'b1;
            else if (cmp_clr)
                cmp_flag_r <= 1'b0;
            if (tick & ovf_set)
                ovf_flag_r <= 1'b1;
            else if (ovf_clr)
                ovf_flag_r <= 1'b0;
        end
    end

    // waveform register and the pin-side outputs
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wave_r <= 1'b0;
            o_wave <= 1'b0;
            o_wave_override <= 1'b0;
        end
        else
        begin
            wave_r <= wave_nxt;
            // pin shows wave only when connected; direction is software's
            o_wave_override <= wave_on;
            o_wave <= wave_r & wave_on;
        end
    end

    // interrupt requests, one cycle behind the flags
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_cmp_irq <= 1'b0;
            o_ovf_irq <= 1'b0;
        end
        else
        begin
            o_cmp_irq <= cmp_flag_r & mask_r[`TMW_BIT_CMP] &
                         i_global_irq_en;
            o_ovf_irq <= ovf_flag_r & mask_r[`TMW_BIT_OVF] &
                         i_global_irq_en;
        end
    end

    // read data stand only in the cycle after the strobe, else zero
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_rdata <= `TMW_ZERO8;
        else if (i_rd)
            o_rdata <= rdata_nxt;
        else
            o_rdata <= `TMW_ZERO8;
    end
endmodule
`default_nettype wire

// ---- test/tmw_timer8_assertions.sv ----
`include "tmw_map.vh"
`default_nettype none
module tmw_timer8_assertions
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_global_irq_en,
    input wire logic o_cmp_irq,
    input wire logic o_ovf_irq,
    input wire logic o_wave,
    input wire logic o_wave_override
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // shadow of the enables and clock select, tracked from bus writes
    logic [1:0] mask_q;
    logic [2:0] cs_q;
    wire logic wr_ctrl = i_wr && i_addr == `TMW_REG_CTRL;
    // shadows follow the write strobe on the same edge as the block
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            mask_q <= 2'h0;
            cs_q <= 3'h0;
        end
        else
        begin
            if (i_wr && i_addr == `TMW_REG_MASK)
                mask_q <= i_wdata[1:0];
            if (wr_ctrl)
                cs_q <= i_wdata[2:0];
        end
    end
    a_reset_quiet: assert property ($fell(i_sys_rst) |->
        !o_wave && !o_wave_override && !o_cmp_irq && !o_ovf_irq)
        else $error("outputs not idle after reset");
    a_cmp_irq_gate: assert property (o_cmp_irq |->
        $past(i_global_irq_en && mask_q[1]))
        else $error("compare request without enable");
    a_ovf_irq_gate: assert property (o_ovf_irq |->
        $past(i_global_irq_en && mask_q[0]))
        else $error("overflow request without enable");
    a_mask_readback: assert property ($past(i_rd && i_addr == 3'h3) |->
        o_rdata == {6'h0, $past(mask_q)})
        else $error("mask readback wrong");
    a_force_reads_zero: assert property ($past(i_rd && i_addr == 3'h0) |->
        !o_rdata[7])
        else $error("force bit read as one");
    a_flags_upper_zero: assert property ($past(i_rd && i_addr == 3'h4) |->
        o_rdata[7:2] == 6'h0)
        else $error("flag upper bits not zero");
    a_override_com: assert property (wr_ctrl ##1 !wr_ctrl |=>
        o_wave_override == ($past(i_wdata[5:4], 2) != 2'h0))
        else $error("override does not follow output mode");
    a_stopped_still: assert property ((cs_q == 3'h0 && !wr_ctrl) [*6] |->
        $stable(o_wave))
        else $error("output moved while timer stopped");
    c_ovf_irq: cover property (o_ovf_irq);
    c_cmp_irq: cover property (o_cmp_irq);
    c_wave_rise: cover property ($rose(o_wave));
endmodule
bind tmw_timer8 tmw_timer8_assertions u_chk (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_global_irq_en(i_global_irq_en),
    .o_cmp_irq(o_cmp_irq), .o_ovf_irq(o_ovf_irq), .o_wave(o_wave),
    .o_wave_override(o_wave_override));
`default_nettype wire

// ---- test/timer8_waveform_unit_tb_top.sv ----
`include "tmw_map.vh"
`default_nettype none
module timer8_waveform_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_ext_pin = 0;
    logic i_global_irq_en = 0, i_cmp_vector_ack = 0, i_ovf_vector_ack = 0;
    logic [2:0] i_addr = 0;
    logic [7:0] i_wdata = 0, o_rdata;
    logic o_cmp_irq, o_ovf_irq, o_wave, o_wave_override;
    int num_errors = 0, samples_checked = 0;
    // force table: set, clear, toggle twice, then two pwm modes
    logic [7:0] fc [6] = '{8'hf0, 8'he0, 8'hd0, 8'hd0, 8'hf8, 8'h98};
    int dv [5] = '{1, 8, 64, 256, 1024}; // prescale ratios per code
    tmw_timer8 tmw_timer8_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_ext_pin(i_ext_pin),
        .i_global_irq_en(i_global_irq_en),
        .i_cmp_vector_ack(i_cmp_vector_ack),
        .i_ovf_vector_ack(i_ovf_vector_ack), .o_cmp_irq(o_cmp_irq),
        .o_ovf_irq(o_ovf_irq), .o_wave(o_wave),
        .o_wave_override(o_wave_override));
    always #25 i_clk = ~i_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // one-cycle write strobe, released on the following edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        d = o_rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // counts from a free-running prescaler land within a small window
    task automatic chk_near(input logic [7:0] got, input int exp);
        samples_checked++;
        if ($isunknown(got) || int'(got) > exp + 3 || int'(got) + 3 < exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t count %h near %0d", $time, got, exp);
        end
    endtask
    // high cycles of the output over whole pwm periods
    task automatic chk_duty(input int got, input int exp);
        samples_checked++;
        if (got != exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t duty %0d exp %0d", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog: the sequence needs about 14000 cycles
    initial
    begin
        #(40000 * 50);
        num_errors++;
        stop_test();
    end
    initial
    begin
        logic [7:0] d;
        logic wv;
        int n, hi, e;
        void'($urandom(93));
        wv = 1'b0;
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int a = 0; a < 6; a++)
            chk_reg(a[2:0], 8'h00);
        wr(`TMW_REG_MASK, 8'hff);
        chk_reg(`TMW_REG_MASK, 8'h03);
        for (int k = 0; k < 4; k++)
        begin
            d = 8'($urandom);
            wr(`TMW_REG_CMP, d);
            chk_reg(`TMW_REG_CMP, d);
            wr(`TMW_REG_CNT, ~d);
            chk_reg(`TMW_REG_CNT, ~d);
        end
        // forced compares with counter equal to compare, timer stopped
        wr(`TMW_REG_CNT, 8'h05);
        wr(`TMW_REG_CMP, 8'h05);
        for (int k = 0; k < 6; k++)
        begin
            wr(`TMW_REG_CTRL, fc[k]);
            if (!fc[k][3])
                wv = fc[k][5:4] == 2'h1 ? !wv : fc[k][5:4] == 2'h3;
            cyc(2);
            #1;
            chk({6'h0, o_wave_override, o_wave},
                {6'h0, fc[k][5:4] != 0, fc[k][5:4] != 0 && wv});
        end
        chk_reg(`TMW_REG_CNT, 8'h05);
        chk_reg(`TMW_REG_FLAGS, 8'h00);
        chk_reg(`TMW_REG_CTRL, 8'h18);
        // external edges: falling then rising
        for (int c = 6; c < 8; c++)
        begin
            wr(`TMW_REG_CNT, 8'h00);
            wr(`TMW_REG_CTRL, c[7:0]);
            repeat (5)
            begin
                cyc(4);
                i_ext_pin <= 1'b1;
                cyc(4);
                i_ext_pin <= 1'b0;
            end
            cyc(8);
            wr(`TMW_REG_CTRL, 8'h00);
            chk_reg(`TMW_REG_CNT, 8'h05);
        end
        for (int c = 1; c < 6; c++)
        begin
            n = c < 3 ? 200 : 3100;
            wr(`TMW_REG_CNT, 8'h00);
            wr(`TMW_REG_CTRL, c[7:0]);
            cyc(n);
            wr(`TMW_REG_CTRL, 8'h00);
            rd(`TMW_REG_CNT, d);
            chk_near(d, n / dv[c - 1]);
        end
        // run across MAX with toggle on compare 2
        wr(`TMW_REG_FLAGS, 8'h03);
        wr(`TMW_REG_CMP, 8'h02);
        wr(`TMW_REG_CNT, 8'hfd);
        wr(`TMW_REG_CTRL, 8'h11);
        cyc(6);
        wr(`TMW_REG_CTRL, 8'h10);
        chk_reg(`TMW_REG_FLAGS, 8'h03);
        chk({5'h0, o_cmp_irq, o_ovf_irq, o_wave}, 8'h01);
        i_global_irq_en <= 1'b1;
        cyc(3);
        #1;
        chk({6'h0, o_cmp_irq, o_ovf_irq}, 8'h03);
        wr(`TMW_REG_FLAGS, 8'h00);
        chk_reg(`TMW_REG_FLAGS, 8'h03);
        @(posedge i_clk);
        i_ovf_vector_ack <= 1'b1;
        @(posedge i_clk);
        i_ovf_vector_ack <= 1'b0;
        chk_reg(`TMW_REG_FLAGS, 8'h02);
        wr(`TMW_REG_FLAGS, 8'h02);
        chk_reg(`TMW_REG_FLAGS, 8'h00);
        // clear-on-match never leaves 0..9 and never overflows
        wr(`TMW_REG_CNT, 8'h00);
        wr(`TMW_REG_CMP, 8'h09);
        wr(`TMW_REG_CTRL, 8'h41);
        cyc(40);
        wr(`TMW_REG_CTRL, 8'h40);
        rd(`TMW_REG_CNT, d);
        chk({7'h0, d <= 8'h09}, 8'h01);
        chk_reg(`TMW_REG_FLAGS, 8'h02);
        @(posedge i_clk);
        i_cmp_vector_ack <= 1'b1;
        @(posedge i_clk);
        i_cmp_vector_ack <= 1'b0;
        chk_reg(`TMW_REG_FLAGS, 8'h00);
        // pwm duty: fast high cmp+1 of 256, phase 2*cmp of 510
        for (int m = 0; m < 3; m++)
        begin
            d = m == 2 ? `TMW_MAX : 8'($urandom_range(254, 1));
            wr(`TMW_REG_CMP, d);
            wr(`TMW_REG_CTRL, m == 1 ? 8'h29 : 8'h69);
            n = m == 1 ? 1020 : 512;
            e = m == 1 ? 4 * d : 2 * d + 2;
            cyc(600);
            hi = 0;
            repeat (n)
            begin
                @(posedge i_clk);
                hi += int'(o_wave);
            end
            wr(`TMW_REG_CTRL, 8'h00);
            chk_duty(hi, e);
        end
        stop_test();
    end
endmodule
`default_nettype wire
